// >>> rtl/swcwk_top.sv
// swcwk_top: mode, wake and sleep control of a single-wire bus transceiver,
// with driver gating, receiver gating, load switch and an apb register file.
// assumes pins arrive asynchronously and analog comparators do the sensing.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`include "swcwk_map.svh"
module swcwk_top #(
    parameter int unsigned HOLD_TICKS = `SWCWK_HOLD_MS * `SWCWK_OSC_KHZ
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    input wire swcwk_pkg::swcwk_pins_t pins,
    input wire swcwk_pkg::swcwk_apb_req_t apb_req,
    output swcwk_pkg::swcwk_apb_rsp_t apb_rsp,
    output logic regulator_enable_out,
    output logic bus_line_driver_en,
    output logic bus_dominant_drive,
    output logic bus_hv_drive,
    output logic waveshape_en,
    output logic rxd_out,
    output logic rxd_oe_n,
    output logic load_switch_on
);
    import swcwk_pkg::*;

    localparam int PIN_W = $bits(swcwk_pins_t);
    // idle levels after reset, so a high txd is not seen as a false dominant
    localparam logic [PIN_W-1:0] PIN_RST = `SWCWK_PIN_RST;
    // cycles of the core clock per tick of the internal oscillator
    localparam int DIV_CYCLES = `SWCWK_CLK_KHZ / `SWCWK_OSC_KHZ;
    localparam logic [`SWCWK_DIV_W-1:0] DIV_LAST = `SWCWK_DIV_W'(DIV_CYCLES - 1);
    // [RULE19] hold length sets the enable fall delay
    localparam logic [`SWCWK_HOLD_W-1:0] HOLD_LAST = `SWCWK_HOLD_W'(HOLD_TICKS - 1);

    // two-flop synchronisers, one per pin bit
    logic [PIN_W-1:0] sync1_reg;
    logic [PIN_W-1:0] sync2_reg;
    swcwk_pins_t pin_s;

    // [RULE17] mode pins reset low so undriven modes read as sleep
    generate
        for (genvar i = 0; i < PIN_W; i++) begin : g_sync
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    sync1_reg[i] <= PIN_RST[i];
                    sync2_reg[i] <= PIN_RST[i];
                end else if (clk_en) begin
                    sync1_reg[i] <= pins[i];
                    sync2_reg[i] <= sync1_reg[i];
                end
            end
        end
    endgenerate

    assign pin_s = swcwk_pins_t'(sync2_reg);

    // internal oscillator: a tick every DIV_CYCLES core cycles
    logic [`SWCWK_DIV_W-1:0] div_reg;
    logic [`SWCWK_DIV_W-1:0] div_next;
    logic tick_reg;
    logic tick_next;

    // [RULE6] 500 kHz tick derived from core clock
    always_comb begin
        tick_next = 1'b0;
        div_next = div_reg + `SWCWK_DIV_W'(1);
        if (div_reg == DIV_LAST) begin
            div_next = '0;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            div_reg <= '0;
            tick_reg <= 1'b0;
        end else if (clk_en) begin
            div_reg <= div_next;
            tick_reg <= tick_next;
        end
    end

    // [RULE9] high-voltage wake level filtered against glitches
    logic hv_filt;

    swcwk_deglitch u_hv_filter (
        .clock(clock),
        .rstn(rstn),
        .clk_en(clk_en),
        .tick(tick_reg),
        .raw(pin_s.high_voltage_wakeup),
        .filt(hv_filt)
    );

    // [RULE16] decode the mode pins into the mode type
    swcwk_mode_t mode;
    assign mode = swcwk_mode_t'({pin_s.mode_select_b, pin_s.mode_select_a});

    // software registers
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic [`SWCWK_EXT_W-1:0] ext_reg;
    logic [`SWCWK_EXT_W-1:0] ext_next;
    logic reduced_pin;
    assign reduced_pin = ctrl_reg[`SWCWK_CTRL_REDUCED_BIT];

    // wake and sleep state machine with its hold timer
    swcwk_state_t state_reg;
    swcwk_state_t state_next;
    logic [`SWCWK_HOLD_W-1:0] hold_reg;
    logic [`SWCWK_HOLD_W-1:0] hold_next;
    logic hv_prev_reg;
    logic hv_prev_next;
    logic hv_rise;
    logic hv_fall;
    logic hold_done;

    assign hv_rise = hv_filt & ~hv_prev_reg;
    assign hv_fall = ~hv_filt & hv_prev_reg;
    assign hold_done = tick_reg && (hold_reg == HOLD_LAST);

    // only a fresh wake edge leaves sleep, so a bus stuck high cannot
    // pull the part straight back after a forced return to sleep
    always_comb begin
        state_next = state_reg;
        hold_next = hold_reg;
        hv_prev_next = hv_filt;
        case (state_reg)
            SWCWK_ST_SLEEP: begin
                hold_next = '0;
                // [RULE8] filtered wake feeds mode control
                if (hv_rise) begin
                    // [RULE1] wake raises regulator enable
                    state_next = SWCWK_ST_HOLD;
                end
            end
            SWCWK_ST_HOLD: begin
                // [RULE3] host claims the part with a non-sleep mode
                if (mode != SWCWK_MODE_SLEEP) begin
                    state_next = SWCWK_ST_AWAKE;
                    hold_next = '0;
                // [RULE4] wake end restarts the hold delay
                end else if (hv_fall) begin
                    hold_next = '0;
                // [RULE5] delay over with modes low: sleep
                end else if (hold_done) begin
                    state_next = SWCWK_ST_SLEEP;
                    hold_next = '0;
                // [RULE20] hold counts oscillator ticks
                end else if (tick_reg) begin
                    hold_next = hold_reg + `SWCWK_HOLD_W'(1);
                end
            end
            SWCWK_ST_AWAKE: begin
                hold_next = '0;
                // sleep request from the host still waits out the hold
                if (mode == SWCWK_MODE_SLEEP) begin
                    state_next = SWCWK_ST_HOLD;
                end
            end
            default: begin
                state_next = SWCWK_ST_SLEEP;
                hold_next = '0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg <= SWCWK_ST_SLEEP;
            hold_reg <= '0;
            hv_prev_reg <= 1'b0;
        end else if (clk_en) begin
            state_reg <= state_next;
            hold_reg <= hold_next;
            hv_prev_reg <= hv_prev_next;
        end
    end

    // driver extension after the transmitter returns to passive
    logic [`SWCWK_EXT_W-1:0] ext_cnt_reg;
    logic [`SWCWK_EXT_W-1:0] ext_cnt_next;
    logic tx_dominant;
    logic drv_active;
    logic awake;

    // [RULE18] low transmit input means dominant bus
    assign tx_dominant = ~pin_s.txd;
    assign awake = (state_reg != SWCWK_ST_SLEEP) || (mode != SWCWK_MODE_SLEEP);
    assign drv_active = tx_dominant || (ext_cnt_reg != '0);

    // [RULE7] keep driver active for ext ticks
    always_comb begin
        ext_cnt_next = ext_cnt_reg;
        if (tx_dominant) begin
            ext_cnt_next = ext_reg;
        // [RULE20] extension counts oscillator ticks
        end else if (tick_reg && (ext_cnt_reg != '0)) begin
            ext_cnt_next = ext_cnt_reg - `SWCWK_EXT_W'(1);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ext_cnt_reg <= '0;
        end else if (clk_en) begin
            ext_cnt_reg <= ext_cnt_next;
        end
    end

    // pin outputs, all registered
    logic regen_next;
    logic drv_en_next;
    logic dom_next;
    logic hv_drv_next;
    logic shape_next;
    logic rxd_oe_n_next;
    logic load_next;

    always_comb begin
        // [RULE2] sleep drops regulator enable
        regen_next = (state_reg != SWCWK_ST_SLEEP);
        // [RULE15] reduced-pin part never drives it
        if (reduced_pin) begin
            regen_next = 1'b0;
        end
        // [RULE10] undervoltage blanks driver and receiver
        drv_en_next = drv_active && awake && !pin_s.undervoltage;
        dom_next = tx_dominant && awake && !pin_s.undervoltage;
        // [RULE13] high-voltage drive only in wake mode
        hv_drv_next = dom_next && (mode == SWCWK_MODE_WAKE);
        // [RULE14] no waveshaping in high speed mode
        shape_next = (mode != SWCWK_MODE_FAST);
        // receiver is off in sleep unless a wake level is present
        rxd_oe_n_next = 1'b1;
        if (pin_s.bus_dominant && !pin_s.undervoltage && (awake || hv_filt)) begin
            rxd_oe_n_next = 1'b0;
        end
        // [RULE11] ground loss opens the load switch
        // [RULE12] loss seen as low battery-ground voltage
        load_next = !pin_s.battery_supply_low;
    end

    logic regen_reg;
    logic drv_en_reg;
    logic dom_reg;
    logic hv_drv_reg;
    logic shape_reg;
    logic rxd_oe_n_reg;
    logic load_reg;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            regen_reg <= 1'b0;
            drv_en_reg <= 1'b0;
            dom_reg <= 1'b0;
            hv_drv_reg <= 1'b0;
            shape_reg <= 1'b1;
            rxd_oe_n_reg <= 1'b1;
            load_reg <= 1'b0;
        end else if (clk_en) begin
            regen_reg <= regen_next;
            drv_en_reg <= drv_en_next;
            dom_reg <= dom_next;
            hv_drv_reg <= hv_drv_next;
            shape_reg <= shape_next;
            rxd_oe_n_reg <= rxd_oe_n_next;
            load_reg <= load_next;
        end
    end

    // apb slave: zero wait states; the answer is prepared in setup
    swcwk_apb_rsp_t rsp_reg;
    swcwk_apb_rsp_t rsp_next;
    logic [31:0] status_word;
    logic setup;
    logic access;
    logic hit;

    assign setup = apb_req.psel && !apb_req.penable;
    assign access = apb_req.psel && apb_req.penable && rsp_reg.pready;

    // status shows live state for software
    always_comb begin
        status_word = '0;
        status_word[`SWCWK_ST_REGEN_BIT] = regen_reg;
        status_word[`SWCWK_ST_HV_BIT] = hv_filt;
        status_word[`SWCWK_ST_UV_BIT] = pin_s.undervoltage;
        status_word[`SWCWK_ST_GND_BIT] = pin_s.battery_supply_low;
        status_word[`SWCWK_ST_DRV_BIT] = drv_en_reg;
        status_word[`SWCWK_ST_MODE_LSB +: 2] = mode;
        status_word[`SWCWK_ST_STATE_LSB +: 2] = state_reg;
    end

    always_comb begin
        hit = (apb_req.paddr == `SWCWK_CTRL_OFF) || (apb_req.paddr == `SWCWK_EXT_OFF)
            || (apb_req.paddr == `SWCWK_STATUS_OFF && !apb_req.pwrite);
        rsp_next = '0;
        if (setup) begin
            rsp_next.pready = 1'b1;
            rsp_next.pslverr = !hit;
            if (!apb_req.pwrite) begin
                case (apb_req.paddr)
                    `SWCWK_CTRL_OFF: rsp_next.prdata = ctrl_reg;
                    `SWCWK_STATUS_OFF: rsp_next.prdata = status_word;
                    `SWCWK_EXT_OFF: rsp_next.prdata = {24'h000000, ext_reg};
                    default: rsp_next.prdata = 32'h00000000;
                endcase
            end
        end
    end

    // writes land only at the completing edge of the access phase
    always_comb begin
        ctrl_next = ctrl_reg;
        ext_next = ext_reg;
        if (access && apb_req.pwrite) begin
            if (apb_req.paddr == `SWCWK_CTRL_OFF) begin
                ctrl_next = 32'h00000000;
                ctrl_next[`SWCWK_CTRL_REDUCED_BIT] = apb_req.pwdata[`SWCWK_CTRL_REDUCED_BIT];
            end
            if (apb_req.paddr == `SWCWK_EXT_OFF) begin
                ext_next = apb_req.pwdata[`SWCWK_EXT_W-1:0];
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rsp_reg <= '0;
            ctrl_reg <= `SWCWK_CTRL_RST;
            ext_reg <= `SWCWK_EXT_RST;
        end else if (clk_en) begin
            rsp_reg <= rsp_next;
            ctrl_reg <= ctrl_next;
            ext_reg <= ext_next;
        end
    end

    // rxd is open drain: the pulled level is low whenever enabled
    logic rxd_out_reg;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rxd_out_reg <= 1'b0;
        end else if (clk_en) begin
            rxd_out_reg <= 1'b0;
        end
    end

    // output ports
    assign apb_rsp = rsp_reg;
    assign regulator_enable_out = regen_reg;
    assign bus_line_driver_en = drv_en_reg;
    assign bus_dominant_drive = dom_reg;
    assign bus_hv_drive = hv_drv_reg;
    assign waveshape_en = shape_reg;
    assign rxd_out = rxd_out_reg;
    assign rxd_oe_n = rxd_oe_n_reg;
    assign load_switch_on = load_reg;

endmodule : swcwk_top

// >>> rtl/swcwk_map.svh
// swcwk_map.svh: offsets, field positions, reset values and timing counts
// of the single-wire bus wake and sleep control block.
// assumes a 250 MHz core clock and an APB slave with 32-bit data.
// What this block does
// [RULE1] bus wake-up raises regulator enable
// [RULE2] regulator enable low during sleep
// [RULE3] host sets non-sleep mode after wake
// [RULE4] hold regulator enable after wake ends
// [RULE5] hold expired, modes low: sleep anyway
// [RULE6] internal 500 kHz oscillator times delays
// [RULE7] driver stays active after passive level
// [RULE8] wake detect feeds mode and timers
// [RULE9] wake indication is deglitched
// [RULE10] undervoltage disables receiver and driver
// [RULE11] ground loss opens load switch
// [RULE12] ground loss means low battery-ground voltage
// [RULE13] high-voltage drive only when mode allows
// [RULE14] waveshaping except in high speed mode
// [RULE15] reduced-pin parts have no regulator enable
// [RULE16] mode pins: 00 sleep,01 wake,10 fast,11 normal
// [RULE17] undriven mode pins mean sleep
// [RULE18] transmit input inverted onto bus
// [RULE19] regulator enable falls 300 to 1000 ms later
// [RULE20] delays count internal oscillator ticks
`ifndef SWCWK_MAP_SVH
`define SWCWK_MAP_SVH

// register byte offsets
`define SWCWK_CTRL_OFF 8'h00
`define SWCWK_STATUS_OFF 8'h04
`define SWCWK_EXT_OFF 8'h08

// control register fields
`define SWCWK_CTRL_REDUCED_BIT 0
`define SWCWK_CTRL_RST 32'h00000000

// driver extension register: ticks of the internal oscillator
`define SWCWK_EXT_W 8
`define SWCWK_EXT_RST 8'h04

// pin synchroniser reset: idle levels, transmit input high
`define SWCWK_PIN_RST 7'h10

// status register fields
`define SWCWK_ST_REGEN_BIT 0
`define SWCWK_ST_HV_BIT 1
`define SWCWK_ST_UV_BIT 2
`define SWCWK_ST_GND_BIT 3
`define SWCWK_ST_DRV_BIT 4
`define SWCWK_ST_MODE_LSB 5
`define SWCWK_ST_STATE_LSB 7

// timing
`define SWCWK_CLK_KHZ 250000
`define SWCWK_OSC_KHZ 500
`define SWCWK_HOLD_MS 500
`define SWCWK_HOLD_W 20
`define SWCWK_DIV_W 9
`define SWCWK_GLITCH_TICKS 4'h8
`define SWCWK_GLITCH_W 4

`endif

// >>> rtl/swcwk_pkg.sv
// swcwk_pkg: types shared by the wake and sleep control block.
// assumes swcwk_map.svh supplies all numbers.
package swcwk_pkg;

    // operating mode as coded on the two mode pins (b, a)
    typedef enum logic [1:0] {
        SWCWK_MODE_SLEEP = 2'b00,
        SWCWK_MODE_WAKE = 2'b10,
        SWCWK_MODE_FAST = 2'b01,
        SWCWK_MODE_NORMAL = 2'b11
    } swcwk_mode_t;

    // regulator control states
    typedef enum logic [1:0] {
        SWCWK_ST_SLEEP = 2'b00,
        SWCWK_ST_HOLD = 2'b01,
        SWCWK_ST_AWAKE = 2'b10
    } swcwk_state_t;

    // pin-level inputs, all asynchronous to the core clock
    typedef struct packed {
        logic mode_select_a;
        logic mode_select_b;
        logic txd;
        logic bus_dominant;
        logic high_voltage_wakeup;
        logic undervoltage;
        logic battery_supply_low;
    } swcwk_pins_t;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } swcwk_apb_req_t;

    // apb answer to the master
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } swcwk_apb_rsp_t;

endpackage : swcwk_pkg

// >>> rtl/swcwk_deglitch.sv
// swcwk_deglitch: level filter that only follows its input after it has
// held a new level for a fixed number of oscillator ticks.
// assumes a synchronised input and a one-cycle tick strobe.
`timescale 1ns/1ns
`include "swcwk_map.svh"
module swcwk_deglitch (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic tick,
    input wire logic raw,
    output logic filt
);
    import swcwk_pkg::*;

    logic filt_reg;
    logic filt_next;
    logic [`SWCWK_GLITCH_W-1:0] cnt_reg;
    logic [`SWCWK_GLITCH_W-1:0] cnt_next;

    // a differing level must survive all ticks; any return restarts it
    always_comb begin
        filt_next = filt_reg;
        cnt_next = cnt_reg;
        if (raw == filt_reg) begin
            cnt_next = '0;
        end else if (tick) begin
            if (cnt_reg == `SWCWK_GLITCH_TICKS - 4'h1) begin
                filt_next = raw;
                cnt_next = '0;
            end else begin
                cnt_next = cnt_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            filt_reg <= 1'b0;
            cnt_reg <= '0;
        end else if (clk_en) begin
            filt_reg <= filt_next;
            cnt_reg <= cnt_next;
        end
    end

    assign filt = filt_reg;

endmodule : swcwk_deglitch

// >>> verif/swcwk_top_chk.sv
// swcwk_top_chk: port-level assertions for the wake and sleep control.
// assumes clk_en stays high while the checks matter.
`timescale 1ns/1ns
module swcwk_top_chk #(
    parameter int unsigned HOLD_TICKS = 4
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    input wire swcwk_pkg::swcwk_pins_t pins,
    input wire swcwk_pkg::swcwk_apb_req_t apb_req,
    input wire swcwk_pkg::swcwk_apb_rsp_t apb_rsp,
    input wire logic regulator_enable_out,
    input wire logic bus_line_driver_en,
    input wire logic bus_dominant_drive,
    input wire logic bus_hv_drive,
    input wire logic waveshape_en,
    input wire logic rxd_out,
    input wire logic rxd_oe_n,
    input wire logic load_switch_on
);
    import swcwk_pkg::*;
    localparam int unsigned HOLD_MIN = (HOLD_TICKS - 1) * 500;
    logic [12:0] hv_reg, hv_next;
    logic [19:0] mz_reg, mz_next;
    // saturating run lengths: steady wake level, and mode pins both low
    always_comb begin
        hv_next = pins.high_voltage_wakeup ? hv_reg + {12'h0, ~&hv_reg} : 13'h0;
        mz_next = (pins.mode_select_a || pins.mode_select_b) ? 20'h0 : mz_reg + {19'h0, ~&mz_reg};
    end
    // counters restart with reset, as the filters inside do
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            hv_reg <= 13'h0;
            mz_reg <= 20'h0;
        end else begin
            hv_reg <= hv_next;
            mz_reg <= mz_next;
        end
    end
    default clocking dcb @(posedge clock); endclocking
    default disable iff (!rstn || !clk_en);
    chk_uv_blocks_bus: assert property (
        pins.undervoltage [*4] |-> !bus_line_driver_en && !bus_dominant_drive && rxd_oe_n
    ) else $error("bus active under undervoltage");
    chk_ground_loss_open: assert property (
        pins.battery_supply_low [*4] |-> !load_switch_on
    ) else $error("load switch closed on ground loss");
    chk_txd_low_dominant: assert property (
        (!pins.txd && !pins.undervoltage && pins.mode_select_a && pins.mode_select_b) [*4]
        |-> bus_dominant_drive
    ) else $error("low transmit input not dominant");
    chk_fast_no_shape: assert property (
        (pins.mode_select_a && !pins.mode_select_b) [*4] |-> !waveshape_en
    ) else $error("waveshaping in high speed mode");
    chk_hv_drive_mode: assert property (
        bus_hv_drive |-> $past(!pins.mode_select_a && pins.mode_select_b, 3)
    ) else $error("high-voltage drive outside wake mode");
    chk_wake_needs_filter: assert property (
        $rose(regulator_enable_out) |-> hv_reg >= 13'hDAC
    ) else $error("regulator enable rose before wake filter");
    chk_hold_before_fall: assert property (
        $fell(regulator_enable_out) |-> mz_reg >= HOLD_MIN
    ) else $error("regulator enable fell before hold delay");
    chk_awake_keeps_reg: assert property (
        (regulator_enable_out && (pins.mode_select_a || pins.mode_select_b)) [*4]
        |=> regulator_enable_out
    ) else $error("regulator enable dropped in non-sleep mode");
    cover property ($rose(regulator_enable_out));
    cover property ($fell(regulator_enable_out));
    cover property (apb_rsp.pready && apb_rsp.pslverr);
endmodule : swcwk_top_chk

bind swcwk_top swcwk_top_chk #(.HOLD_TICKS(HOLD_TICKS)) i_swcwk_top_chk (
    .clock(clock), .rstn(rstn), .clk_en(clk_en), .pins(pins), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .regulator_enable_out(regulator_enable_out),
    .bus_line_driver_en(bus_line_driver_en), .bus_dominant_drive(bus_dominant_drive),
    .bus_hv_drive(bus_hv_drive), .waveshape_en(waveshape_en), .rxd_out(rxd_out),
    .rxd_oe_n(rxd_oe_n), .load_switch_on(load_switch_on));

// >>> verif/swcwk_host.sv
// swcwk_host: host controller side of the mode pins and transmit data.
// assumes the bench asks for a mode and a transmit level.
`timescale 1ns/1ns
module swcwk_host (
    input wire logic clock,
    input wire logic rstn,
    input wire logic drive_en,
    input wire swcwk_pkg::swcwk_mode_t want_mode,
    input wire logic want_txd,
    output logic mode_select_a,
    output logic mode_select_b,
    output logic txd
);
    import swcwk_pkg::*;
    logic [2:0] pin_reg, pin_next;
    // mode coding, b high with a low means wake
    always_comb begin
        pin_next = {want_mode[0], want_mode[1], want_txd};
    end
    // pins change only just after an edge
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pin_reg <= 3'h1;
        end else begin
            pin_reg <= pin_next;
        end
    end
    // released mode pins sit at the pulldown level
    assign mode_select_a = pin_reg[2] & drive_en;
    assign mode_select_b = pin_reg[1] & drive_en;
    assign txd = pin_reg[0] | !rstn;
endmodule : swcwk_host

// >>> verif/swcwk_top_test.sv
// swcwk_top_test: self-checking bench for the wake and sleep control.
// assumes the host model on the mode pins and a short hold count.
`timescale 1ns/1ns
module swcwk_top_test;
    import swcwk_pkg::*;
    typedef struct packed {
        logic [32:0] mask;
        logic [32:0] exp;
    } swcwk_note_t;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic look = 1'b0;
    logic ce = 1'b1;
    logic hv = 1'b0;
    logic bdom = 1'b0;
    logic uv = 1'b0;
    logic gnd = 1'b0;
    logic host_on = 1'b0;
    logic want_txd = 1'b1;
    swcwk_mode_t want_mode = SWCWK_MODE_SLEEP;
    swcwk_apb_req_t apb_req = '0;
    swcwk_apb_rsp_t apb_rsp;
    swcwk_pins_t pins;
    logic ma, mb, txd, regen, drv, dom, hvd, shape, rxd, oe_n, load;
    logic [7:0] pv;
    logic [7:0] rnd;
    swcwk_note_t apb_q[$];
    swcwk_note_t port_q[$];
    swcwk_note_t nt;
    int miscompares = 0;
    int n_compared = 0;
    int seed = 32'hD79FA2B3;
    always #2 clock = ~clock;
    assign pins = {ma, mb, txd, bdom, hv, uv, gnd};
    assign pv = {regen, drv, dom, hvd, shape, rxd, oe_n, load};
    swcwk_host i_swcwk_host (.clock(clock), .rstn(rstn), .drive_en(host_on),
        .want_mode(want_mode), .want_txd(want_txd), .mode_select_a(ma),
        .mode_select_b(mb), .txd(txd));
    // hold count kept small; clk_en driven by the bench
    swcwk_top #(.HOLD_TICKS(4)) i_swcwk_top (.clock(clock), .rstn(rstn), .clk_en(ce),
        .pins(pins), .apb_req(apb_req), .apb_rsp(apb_rsp), .regulator_enable_out(regen),
        .bus_line_driver_en(drv), .bus_dominant_drive(dom), .bus_hv_drive(hvd),
        .waveshape_en(shape), .rxd_out(rxd), .rxd_oe_n(oe_n), .load_switch_on(load));
    task results;
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results
    task bad(input string s);
        $display("CHECK FAILED at %0t: %s", $time, s);
        miscompares++;
    endtask : bad
    // one apb transfer; request held until pready is seen at an edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
             input logic [32:0] m, input logic [32:0] e);
        int n;
        apb_q.push_back({m, e});
        @(posedge clock);
        apb_req.psel <= 1'b1;
        apb_req.pwrite <= wr;
        apb_req.paddr <= a;
        apb_req.pwdata <= d;
        @(posedge clock);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        if (apb_rsp.pready !== 1'b1) begin
            bad("no pready");
            results();
        end
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb
    task rd(input logic [7:0] a, input logic [32:0] e);
        apb(1'b0, a, 32'h0, {1'b1, 32'hFFFFFFFF}, e);
    endtask : rd
    task wr(input logic [7:0] a, input logic [31:0] d, input logic err);
        apb(1'b1, a, d, {1'b1, 32'h0}, {err, 32'h0});
    endtask : wr
    // let pins pass the synchronisers, then note the expected ports
    task pchk(input logic [7:0] m, input logic [7:0] e);
        repeat (6) @(posedge clock);
        port_q.push_back({25'h0, m, 25'h0, e});
        look <= 1'b1;
        @(posedge clock);
        look <= 1'b0;
    endtask : pchk
    task wreg(input logic v, input int lim);
        int n;
        n = 0;
        while (regen !== v && n < lim) begin
            @(posedge clock);
            n++;
        end
        if (regen !== v) begin
            bad("regulator enable wait");
            results();
        end
    endtask : wreg
    // oldest note against each answer as it appears
    always @(posedge clock) begin
        if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1) begin
            nt = apb_q.pop_front();
            n_compared++;
            if ((({apb_rsp.pslverr, apb_rsp.prdata} ^ nt.exp) & nt.mask) !== 33'h0) begin
                bad("apb answer");
            end
        end
        if (look) begin
            nt = port_q.pop_front();
            n_compared++;
            if (((pv ^ nt.exp[7:0]) & nt.mask[7:0]) !== 8'h0) begin
                bad("port levels");
            end
        end
    end
    // main sequence: registers, glitch, forced sleep, awake traffic, faults
    initial begin
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        rd(8'h00, 33'h0);
        rd(8'h08, 33'h4);
        rd(8'h04, 33'h0);
        rnd = 8'($random(seed));
        wr(8'h04, {4{rnd}}, 1'b1);
        rd(8'h0C, {1'b1, 32'h0});
        wr(8'h08, {24'h0, rnd}, 1'b0);
        rd(8'h08, {25'h0, rnd});
        wr(8'h08, 32'h3, 1'b0);
        pchk(8'hF7, 8'h03);
        hv <= 1'b1;
        repeat (2000) @(posedge clock);
        hv <= 1'b0;
        repeat (600) @(posedge clock);
        rd(8'h04, 33'h0);
        hv <= 1'b1;
        wreg(1'b1, 6000);
        rd(8'h04, 33'h083);
        wreg(1'b0, 4000);
        rd(8'h04, 33'h002);
        hv <= 1'b0;
        repeat (5000) @(posedge clock);
        hv <= 1'b1;
        wreg(1'b1, 6000);
        host_on <= 1'b1;
        want_mode <= SWCWK_MODE_NORMAL;
        hv <= 1'b0;
        repeat (5000) @(posedge clock);
        rd(8'h04, 33'h161);
        want_txd <= 1'b0;
        pchk(8'hFF, 8'hEB);
        want_txd <= 1'b1;
        repeat (950) @(posedge clock);
        pchk(8'h60, 8'h40);
        repeat (700) @(posedge clock);
        pchk(8'h40, 8'h00);
        for (int i = 1; i < 4; i++) begin
            want_mode <= swcwk_mode_t'(i[1:0]);
            want_txd <= 1'b0;
            bdom <= i[0];
            pchk(8'hFF, {3'b111, i == 2, i != 1, 1'b0, !i[0], 1'b1});
        end
        ce <= 1'b0;
        gnd <= 1'b1;
        pchk(8'h01, 8'h01);
        ce <= 1'b1;
        gnd <= 1'b0;
        uv <= 1'b1;
        pchk(8'h72, 8'h02);
        uv <= 1'b0;
        gnd <= 1'b1;
        want_txd <= 1'b1;
        pchk(8'h01, 8'h00);
        gnd <= 1'b0;
        host_on <= 1'b0;
        wreg(1'b0, 4000);
        rd(8'h04, 33'h0);
        wr(8'h00, 32'h1, 1'b0);
        hv <= 1'b1;
        repeat (4000) @(posedge clock);
        pchk(8'h80, 8'h00);
        rd(8'h04, 33'h082);
        hv <= 1'b0;
        repeat (5000) @(posedge clock);
        wr(8'h00, 32'h0, 1'b0);
        results();
    end
endmodule : swcwk_top_test
